// >>> core/ebsc_ctrl.sv
`timescale 1ns/1ps
`include "ebsc_defs.svh"
module ebsc_ctrl
	import ebsc_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// straps and pin inputs
	input wire logic i_divider_bypass_pin,
	input wire logic i_mode_select_a,
	input wire logic i_mode_select_b,
	input wire logic i_debug_wire_pin,
	input wire logic i_low_tag_input,
	// internal access request
	input wire logic i_acc_req,
	input wire logic [15:0] i_acc_addr,
	input wire logic i_acc_write,
	input wire logic i_access_size_signal_n,
	input wire logic [1:0] i_acc_stretch,
	input wire logic [3:0] i_queue_state,
	// access answer
	output logic o_acc_done,
	output logic o_acc_refused,
	output logic [15:0] o_bus_addr,
	output logic o_bus_byte_hi,
	// strobe pin
	output logic o_low_byte_strobe_pin,
	output logic o_low_byte_strobe_oe,
	output logic o_low_byte_strobe_pullup,
	output logic o_low_tag_q,
	// bus enable pin
	output logic o_data_bus_enable_n,
	output logic o_data_bus_enable_oe,
	output logic o_data_bus_enable_pullup,
	// read/write pin
	output logic o_rw,
	output logic o_rw_oe,
	output logic o_rw_pullup,
	// bus clock and queue tracking
	output logic o_bus_clock_out,
	output logic o_queue_track_hi,
	output logic o_queue_track_lo,
	output logic o_queue_track_oe
);
	ebsc_st_t q;
	ebsc_st_t d;
	ebsc_clk_if clk_if ();
	logic expanded;
	logic narrow;
	logic tag_mode;
	logic strb_en;
	logic rw_en;
	logic ben_en;
	logic busy;
	logic low_write;
	logic take;
	logic bad;
	logic ben_act;

	// -----------------------------
	// bus clock divider
	// -----------------------------
	ebsc_clkdiv u_div (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_divider_bypass_pin(i_divider_bypass_pin),
		.clk_if(clk_if.src)
	);

	// -----------------------------
	// mode and enable decode
	// -----------------------------
	// mode pins: a high means an expanded mode, b low then narrow
	assign expanded = q.mode_a;
	assign narrow = q.mode_a & ~q.mode_b;
	assign tag_mode = q.special & expanded;
	assign strb_en = q.pinsel[`EBSC_BIT_STREN] & ~tag_mode;
	assign rw_en = q.pinsel[`EBSC_BIT_RWEN] & expanded;
	assign ben_en = expanded & ~q.pinsel[`EBSC_BIT_BENDIS];
	assign busy = (q.state == EBSC_RUN);

	// request screening: a low byte write needs the strobe, a write needs r/w
	assign low_write = i_acc_write & (i_acc_addr[0] ^ i_access_size_signal_n);
	assign take = (q.state == EBSC_IDLE) & i_acc_req & clk_if.last & ~q.done & ~q.refused;
	assign bad = ~expanded | (i_acc_write & ~rw_en) | (low_write & ~strb_en);

	// bus enable window: whole high time, or only the final core clock
	// of the last cycle when the access is stretched
	assign ben_act = busy & clk_if.hi & (~q.stretched | ((q.cyc_left == 2'h0) & clk_if.last));

	// -----------------------------
	// next-state logic
	// -----------------------------
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.refused = 1'b0;
		d.rdata = 8'h00;
		// register writes
		if (i_reg_wr && (i_reg_addr == `EBSC_OFS_PINSEL))
			d.pinsel = i_reg_wdata & `EBSC_PINSEL_MASK;
		// register reads, answered next cycle, unmapped reads zero
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				`EBSC_OFS_PINSEL: d.rdata = q.pinsel;
				`EBSC_OFS_STATUS: d.rdata = {3'h0, tag_mode, busy, q.special, q.mode_b, q.mode_a};
				default: d.rdata = 8'h00;
			endcase
		end
		// bus cycle sequencer, stepping on bus clock boundaries
		case (q.state)
			EBSC_IDLE:
			begin
				if (take && bad)
					d.refused = 1'b1;
				else if (take)
				begin
					d.state = EBSC_RUN;
					d.addr = i_acc_addr;
					d.write = i_acc_write;
					d.size_n = i_access_size_signal_n;
					d.stretch = i_acc_stretch;
					d.cyc_left = i_acc_stretch;
					d.stretched = |i_acc_stretch;
					d.two_byte = narrow & i_access_size_signal_n;
					d.byte_hi = narrow & i_access_size_signal_n;
				end
			end
			EBSC_RUN:
			begin
				if (clk_if.last)
				begin
					if (q.cyc_left != 2'h0)
						d.cyc_left = q.cyc_left - 2'h1;
					else if (q.byte_hi)
					begin
						// high byte done, low byte follows at once
						d.byte_hi = 1'b0;
						d.cyc_left = q.stretch;
					end
					else
					begin
						d.state = EBSC_IDLE;
						d.done = 1'b1;
					end
				end
			end
			default: d.state = EBSC_IDLE;
		endcase
		// pin outputs; strobe, bus enable and r/w idle-inactive outside a bus cycle, bus clock free-running
		d.strb = busy ? ~(q.addr[0] ^ q.size_n) : `EBSC_STRB_IDLE;
		d.strb_oe = strb_en;
		d.strb_pu = ~strb_en & ~tag_mode;
		d.tag_lo = tag_mode & i_low_tag_input;
		d.ben_n = (ben_act & ben_en) ? 1'b0 : `EBSC_BEN_IDLE;
		d.ben_oe = ben_en;
		d.ben_pu = ~expanded;
		d.rw = busy ? ~q.write : `EBSC_RW_READ;
		d.rw_oe = rw_en;
		d.rw_pu = ~rw_en;
		d.bclk = clk_if.hi;
		// queue state, low pair in the low half, high pair in the high half
		d.qhi = clk_if.hi ? i_queue_state[3] : i_queue_state[1];
		d.qlo = clk_if.hi ? i_queue_state[2] : i_queue_state[0];
		d.q_oe = q.pinsel[`EBSC_BIT_QTE];
		// sync reset; mode and debug straps are caught while reset is held, the bypass strap is not
		if (i_srst)
		begin
			d = '0;
			d.state = EBSC_IDLE;
			d.pinsel = `EBSC_PINSEL_RST;
			d.mode_a = i_mode_select_a;
			d.mode_b = i_mode_select_b;
			d.special = ~i_debug_wire_pin;
			d.strb = `EBSC_STRB_IDLE;
			d.strb_pu = 1'b1;
			d.ben_n = `EBSC_BEN_IDLE;
			d.ben_pu = 1'b1;
			d.rw = `EBSC_RW_READ;
			d.rw_pu = 1'b1;
		end
	end

	// -----------------------------
	// state register
	// -----------------------------
	always_ff @(posedge i_core_clk)
	begin
		q <= d;
	end

	// outputs straight from the state register
	assign o_reg_rdata = q.rdata;
	assign o_acc_done = q.done;
	assign o_acc_refused = q.refused;
	assign o_bus_addr = q.addr;
	assign o_bus_byte_hi = q.byte_hi;
	assign o_low_byte_strobe_pin = q.strb;
	assign o_low_byte_strobe_oe = q.strb_oe;
	assign o_low_byte_strobe_pullup = q.strb_pu;
	assign o_low_tag_q = q.tag_lo;
	assign o_data_bus_enable_n = q.ben_n;
	assign o_data_bus_enable_oe = q.ben_oe;
	assign o_data_bus_enable_pullup = q.ben_pu;
	assign o_rw = q.rw;
	assign o_rw_oe = q.rw_oe;
	assign o_rw_pullup = q.rw_pu;
	assign o_bus_clock_out = q.bclk;
	assign o_queue_track_hi = q.qhi;
	assign o_queue_track_lo = q.qlo;
	assign o_queue_track_oe = q.q_oe;

	// -----------------------------
	// checks
	// -----------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence s_take_write;
		(q.state == EBSC_IDLE) && i_acc_req && i_acc_write && clk_if.last && !q.done && !q.refused;
	endsequence
	sequence s_start_wide;
		$rose(busy) && q.two_byte;
	endsequence

	AST_STRB_XNOR: assert property (busy |=>
		(o_low_byte_strobe_pin == ~($past(q.addr[0]) ^ $past(q.size_n))))
		else $error("strobe is not xnor of a0 and size");
	AST_IDLE_QUIET: assert property ((q.state == EBSC_IDLE) |=>
		(o_low_byte_strobe_pin && o_data_bus_enable_n && o_rw))
		else $error("bus control active outside a bus cycle");
	AST_BEN_IN_HIGH: assert property (!o_data_bus_enable_n |-> o_bus_clock_out)
		else $error("bus enable low while bus clock low");
	AST_BEN_PLAIN: assert property ((busy && !q.stretched && clk_if.hi && ben_en)
		|=> !o_data_bus_enable_n)
		else $error("bus enable missing in bus clock high time");
	AST_BEN_STRETCH: assert property ((!o_data_bus_enable_n && $past(q.stretched))
		|=> o_data_bus_enable_n)
		else $error("stretched bus enable longer than one quarter");
	AST_BEN_OFF: assert property (q.pinsel[`EBSC_BIT_BENDIS] |=> o_data_bus_enable_n)
		else $error("bus enable driven while disabled");
	AST_RW_REFUSE: assert property ((s_take_write and !rw_en) |=>
		(o_acc_refused && (q.state == EBSC_IDLE)))
		else $error("write taken with read/write disabled");
	AST_LOW_REFUSE: assert property ((s_take_write and (low_write && !strb_en)) |=> o_acc_refused)
		else $error("low byte write taken with strobe disabled");
	AST_NARROW_HI: assert property (s_start_wide |-> q.byte_hi)
		else $error("narrow transfer does not start with high byte");
	AST_MODE_HOLD: assert property (1'b1 |=> $stable({q.mode_a, q.mode_b, q.special}))
		else $error("sampled mode changed after reset");
	AST_STRB_OE: assert property (!q.pinsel[`EBSC_BIT_STREN] |=> !o_low_byte_strobe_oe)
		else $error("strobe driven before enable");
endmodule // ebsc_ctrl

// >>> core/ebsc_defs.svh
`ifndef EBSC_DEFS_SVH
`define EBSC_DEFS_SVH
`define EBSC_OFS_PINSEL 4'h0
`define EBSC_OFS_STATUS 4'h1
`define EBSC_BIT_BENDIS 7
`define EBSC_BIT_QTE 5
`define EBSC_BIT_STREN 4
`define EBSC_BIT_RWEN 3
`define EBSC_PINSEL_RST 8'h00
`define EBSC_PINSEL_MASK 8'hb8
`define EBSC_LAST_DIV4 2'h3
`define EBSC_LAST_DIV2 2'h1
`define EBSC_HI_DIV4 2'h2
`define EBSC_HI_DIV2 2'h1
`define EBSC_STRB_IDLE 1'b1
`define EBSC_BEN_IDLE 1'b1
`define EBSC_RW_READ 1'b1
`endif

// >>> core/ebsc_pkg.sv
package ebsc_pkg;
	typedef enum logic [1:0] {EBSC_IDLE = 2'b00, EBSC_RUN = 2'b01} ebsc_state_t;
	typedef struct packed {
		logic [1:0] cnt;
	} ebsc_div_t;
	typedef struct packed {
		ebsc_state_t state;
		logic [7:0] pinsel;
		logic mode_a;
		logic mode_b;
		logic special;
		logic [15:0] addr;
		logic write;
		logic size_n;
		logic stretched;
		logic two_byte;
		logic byte_hi;
		logic [1:0] stretch;
		logic [1:0] cyc_left;
		logic [7:0] rdata;
		logic strb;
		logic strb_oe;
		logic strb_pu;
		logic ben_n;
		logic ben_oe;
		logic ben_pu;
		logic rw;
		logic rw_oe;
		logic rw_pu;
		logic bclk;
		logic qhi;
		logic qlo;
		logic q_oe;
		logic tag_lo;
		logic done;
		logic refused;
	} ebsc_st_t;
endpackage

// >>> core/ebsc_clk_if.sv
`timescale 1ns/1ps
interface ebsc_clk_if;
	logic [1:0] phase;
	logic hi;
	logic last;
	modport src(output phase, output hi, output last);
	modport snk(input phase, input hi, input last);
endinterface

// >>> core/ebsc_clkdiv.sv
`timescale 1ns/1ps
`include "ebsc_defs.svh"
module ebsc_clkdiv
	import ebsc_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// static test strap
	input wire logic i_divider_bypass_pin,
	// phase to the controller
	ebsc_clk_if.src clk_if
);
	ebsc_div_t q;
	ebsc_div_t d;
	logic [1:0] last_v;
	logic [1:0] hi_v;

	// -----------------------------
	// quarter-phase counter, half-phase with the divider bypass
	// -----------------------------
	// bypass is only read, never latched: it is static by use
	always_comb
	begin
		last_v = i_divider_bypass_pin ? `EBSC_LAST_DIV2 : `EBSC_LAST_DIV4;
		hi_v = i_divider_bypass_pin ? `EBSC_HI_DIV2 : `EBSC_HI_DIV4;
		d = q;
		d.cnt = (q.cnt >= last_v) ? 2'h0 : q.cnt + 2'h1;
		if (i_srst)
			d.cnt = 2'h0;
	end

	always_ff @(posedge i_core_clk)
	begin
		q <= d;
	end

	// phase decode for the controller
	assign clk_if.phase = q.cnt;
	assign clk_if.hi = (q.cnt >= hi_v);
	assign clk_if.last = (q.cnt == last_v);

	AST_DIV4_PERIOD: assert property (@(posedge i_core_clk) disable iff (i_srst)
		($rose(clk_if.hi) ##1 (!i_divider_bypass_pin)[*4]) |-> $rose(clk_if.hi))
		else $error("bus clock period is not four core clocks");
	AST_DIV2_PERIOD: assert property (@(posedge i_core_clk) disable iff (i_srst)
		($rose(clk_if.hi) ##1 i_divider_bypass_pin[*2]) |-> $rose(clk_if.hi))
		else $error("bus clock period is not two core clocks");
endmodule // ebsc_clkdiv

// >>> test/ebsc_ext_mem.sv
`timescale 1ns/1ps
module ebsc_ext_mem
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// observed bus pins
	input wire logic i_bus_clock_out,
	input wire logic i_data_bus_enable_n,
	input wire logic i_rw,
	input wire logic [15:0] i_bus_addr,
	// bookkeeping for the bench
	output logic [15:0] o_addr_latch,
	output logic [7:0] o_drive_cnt
);
	logic bclk_q;
	logic ben_q;
	// --------------------------------------------------------------
	// address capture on the bus clock rising edge and read drive count
	// --------------------------------------------------------------
	// no data pins exist, so a read drive is only counted, never driven
	always_ff @(posedge i_core_clk)
	begin
		bclk_q <= i_bus_clock_out;
		ben_q <= i_data_bus_enable_n;
		if (i_srst)
		begin
			o_addr_latch <= 16'h0000;
			o_drive_cnt <= 8'h00;
		end
		else
		begin
			if (i_bus_clock_out && !bclk_q)
				o_addr_latch <= i_bus_addr;
			if (!i_data_bus_enable_n && ben_q && i_rw)
				o_drive_cnt <= o_drive_cnt + 8'h01;
		end
	end
endmodule // ebsc_ext_mem

// >>> test/ebsc_ctrl_tb.sv
`timescale 1ns/1ps
module ebsc_ctrl_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] ra = 4'h0;
	logic [7:0] wd = 8'h00;
	logic rwr = 1'b0;
	logic rrd = 1'b0;
	logic byp = 1'b0;
	logic ma = 1'b1;
	logic mb = 1'b1;
	logic dbg = 1'b1;
	logic tag = 1'b0;
	logic req = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic wr = 1'b0;
	logic szn = 1'b0;
	logic [1:0] st = 2'h0;
	logic [3:0] qs = 4'h9;
	logic [7:0] rdata, drv;
	logic [15:0] baddr, lat;
	logic done, refd, bhi, strb, strb_oe, strb_pu, tagq, ben, ben_oe, ben_pu, rw, rw_oe, rw_pu, bclk, qhi, qlo, qoe;
	logic rf, sv, rwv, hf, hl, lo;
	int fails = 0;
	int n_compared = 0;
	int nh, nd, bad;

	ebsc_ctrl dut_u
	(
		.i_core_clk(clk), .i_srst(srst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(rwr), .i_reg_rd(rrd),
		.o_reg_rdata(rdata), .i_divider_bypass_pin(byp), .i_mode_select_a(ma), .i_mode_select_b(mb),
		.i_debug_wire_pin(dbg), .i_low_tag_input(tag), .i_acc_req(req), .i_acc_addr(addr), .i_acc_write(wr),
		.i_access_size_signal_n(szn), .i_acc_stretch(st), .i_queue_state(qs), .o_acc_done(done),
		.o_acc_refused(refd), .o_bus_addr(baddr), .o_bus_byte_hi(bhi), .o_low_byte_strobe_pin(strb),
		.o_low_byte_strobe_oe(strb_oe), .o_low_byte_strobe_pullup(strb_pu), .o_low_tag_q(tagq),
		.o_data_bus_enable_n(ben), .o_data_bus_enable_oe(ben_oe), .o_data_bus_enable_pullup(ben_pu), .o_rw(rw),
		.o_rw_oe(rw_oe), .o_rw_pullup(rw_pu), .o_bus_clock_out(bclk), .o_queue_track_hi(qhi),
		.o_queue_track_lo(qlo), .o_queue_track_oe(qoe)
	);
	ebsc_ext_mem prt_u
	(
		.i_core_clk(clk), .i_srst(srst), .i_bus_clock_out(bclk), .i_data_bus_enable_n(ben), .i_rw(rw),
		.i_bus_addr(baddr), .o_addr_latch(lat), .o_drive_cnt(drv)
	);

	// 25 MHz core clock
	initial
	begin
		forever #20 clk = ~clk;
	end

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rst(input logic a, input logic b, input logic d, input logic p);
		@(posedge clk);
		srst <= 1'b1;
		ma <= a;
		mb <= b;
		dbg <= d;
		byp <= p;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		ra <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		#1;
		chk(n, {8'h00, e}, {8'h00, rdata});
	endtask
	// high-time count starts after the first low phase: the pre-take high shows one cycle late
	task automatic acc(input logic [15:0] a, input logic w, input logic z, input logic [1:0] s);
		int i;
		@(posedge clk);
		req <= 1'b1;
		addr <= a;
		wr <= w;
		szn <= z;
		st <= s;
		nh = 0;
		nd = 0;
		bad = 0;
		lo = 1'b0;
		for (i = 0; i < 200; i++)
		begin
			@(posedge clk);
			#1;
			if (ben === 1'b0)
				nd++;
			if (ben === 1'b0 && bclk !== 1'b1)
				bad++;
			// byte flag leads the pins by one clock, so take it in the first low phase
			if (baddr === a && bclk === 1'b0)
			begin
				if (!lo)
					hf = bhi;
				lo = 1'b1;
			end
			if (lo && bclk === 1'b1)
			begin
				nh++;
				hl = bhi;
				sv = strb;
				rwv = rw;
			end
			if (done === 1'b1 || refd === 1'b1)
				break;
		end
		rf = refd;
		@(posedge clk);
		req <= 1'b0;
		if (i == 200)
		begin
			fails++;
			$display("MISMATCH access wait expected done seen none");
			end_of_test();
		end
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		int i;
		int e;
		rst(1'b1, 1'b1, 1'b1, 1'b0);
		chk("idle pins", 16'h00d6, {strb, strb_pu, strb_oe, ben, ben_pu, rw, rw_pu, rw_oe});
		reg_rd(4'h0, 8'h00, "pinsel reset");
		reg_rd(4'h1, 8'h03, "status");
		reg_wr(4'h0, 8'hff);
		reg_rd(4'h0, 8'hb8, "pinsel mask");
		reg_wr(4'hf, 8'hff);
		reg_rd(4'hf, 8'h00, "unmapped");
		reg_wr(4'h0, 8'h00);
		acc(16'h1000, 1'b1, 1'b1, 2'h0);
		chk("rw off", 16'h1, {15'h0, rf});
		reg_wr(4'h0, 8'h08);
		acc(16'h1001, 1'b1, 1'b0, 2'h0);
		chk("strobe off", 16'h1, {15'h0, rf});
		reg_wr(4'h0, 8'h18);
		// enables are registered from the register, so they show one clock after the write
		@(posedge clk);
		#1;
		chk("oe on", 16'h7, {13'h0, ben_oe, strb_oe, rw_oe});
		acc(16'h1001, 1'b1, 1'b0, 2'h0);
		chk("wr hi", 16'h2, nh[15:0]);
		chk("wr strb rw", 16'h0, {14'h0, sv, rwv});
		acc(16'h2003, 1'b0, 1'b1, 2'h0);
		chk("rd strb rw", 16'h3, {14'h0, sv, rwv});
		chk("rd bus enable", 16'h2, nd[15:0]);
		chk("drive", 16'h1, {8'h0, drv});
		acc(16'h3004, 1'b0, 1'b1, 2'h2);
		chk("st hi", 16'h6, nh[15:0]);
		chk("st bus enable", 16'h1, nd[15:0]);
		reg_wr(4'h0, 8'h98);
		acc(16'h4006, 1'b0, 1'b1, 2'h0);
		chk("bus enable off", 16'h0, nd[15:0]);
		chk("bus enable low", 16'h0, bad[15:0]);
		#1;
		chk("idle", 16'h7, {13'h0, ben, strb, rw});
		reg_wr(4'h0, 8'h20);
		e = 0;
		for (i = 0; i < 8; i++)
		begin
			@(posedge clk);
			#1;
			if ({qhi, qlo} !== (bclk ? qs[3:2] : qs[1:0]))
				e++;
		end
		chk("queue", 16'h0, e[15:0]);
		chk("queue oe", 16'h1, {15'h0, qoe});
		$display("test wide done");
		rst(1'b1, 1'b0, 1'b0, 1'b1);
		reg_rd(4'h1, 8'h15, "status");
		@(posedge clk);
		tag <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("tag", 16'h1, {15'h0, tagq});
		reg_wr(4'h0, 8'h18);
		acc(16'h5001, 1'b1, 1'b0, 2'h0);
		chk("tag wr", 16'h1, {15'h0, rf});
		acc(16'h5000, 1'b0, 1'b1, 2'h0);
		chk("narrow hi", 16'h2, nh[15:0]);
		chk("byte order", 16'h2, {14'h0, hf, hl});
		chk("latch", 16'h5000, lat);
		$display("test narrow done");
		rst(1'b0, 1'b0, 1'b1, 1'b0);
		chk("bus enable pullup", 16'h1, {15'h0, ben_pu});
		reg_wr(4'h0, 8'h18);
		acc(16'h6001, 1'b0, 1'b1, 2'h0);
		chk("single", 16'h1, {15'h0, rf});
		chk("rw oe", 16'h0, {15'h0, rw_oe});
		$display("test single done");
		end_of_test();
	end
endmodule // ebsc_ctrl_tb
